// File: rtl/egress_stats_pkg.sv
// Package for the egress router leg statistics block.
// Assumes one core clock; software reaches it over Avalon-MM.
package egress_stats_pkg;
  localparam int LEGS = 4;
  localparam int LEG_W = 2;
  localparam int PAIRS = 8;
  localparam int PAIR_W = 3;
  localparam int EVENTS = 5;
  localparam int CNT_W = 32;
  localparam int LEN_W = 14;
  localparam int ADDR_W = 8;

  // Event bit positions inside an event vector and a pair mask
  localparam int EV_UC_ROUTED = 0;
  localparam int EV_MC_ROUTED = 1;
  localparam int EV_MC_BRIDGED = 2;
  localparam int EV_MC_TTL_DROP = 3;
  localparam int EV_ACL_DROP = 4;

  // Register map, byte addresses
  // 0x00 + 4*pair : pair config, bits 4:0 event mask, bit 8 byte mode
  // 0x20 : counter select, bits 1:0 leg, bits 4:2 pair, bit 5 ipv6
  // 0x24 : counter value of the selected counter (read), any write clears it
  // 0x28 : v4 multicast ttl threshold, bits 7:0
  // 0x2c : v6 multicast ttl threshold, bits 7:0
  localparam logic [ADDR_W-1:0] PAIR_CFG_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] CNT_SEL_OFF = 8'h20;
  localparam logic [ADDR_W-1:0] CNT_VAL_OFF = 8'h24;
  localparam logic [ADDR_W-1:0] V4_TTL_OFF = 8'h28;
  localparam logic [ADDR_W-1:0] V6_TTL_OFF = 8'h2c;
  localparam int BYTE_MODE_BIT = 8;
  localparam int SEL_PAIR_LSB = 2;
  localparam int SEL_V6_BIT = 5;
  localparam logic [EVENTS-1:0] MASK_RESET = 5'h00;
  localparam logic [7:0] TTL_RESET = 8'h01;

  // Frame descriptor from the routing analyser, one per valid cycle
  typedef struct packed {
    logic [LEG_W-1:0] leg;
    logic is_v6;
    logic is_multicast;
    logic l3_forwarded;
    logic l2_forwarded;
    logic acl_dropped;
    logic [7:0] ttl;
    logic [LEN_W-1:0] length;
  } frame_desc_t;

  typedef struct packed {
    logic [EVENTS-1:0] mask;
    logic byte_mode;
  } pair_cfg_t;
endpackage

// File: rtl/egress_router_leg_stats.sv
// Egress router leg statistics: event generation and per-leg counter pairs.
// Assumes frame descriptors synchronous to clk, one per cycle at most;
// registers reached over Avalon-MM, fixed one wait cycle on each access.
//
// Functional notes
// - Unicast frame routed out of leg raises event
// - Multicast frame routed out of leg raises event
// - Multicast frame bridged at layer two raises event
// - Multicast TTL threshold drop raises event, per version
// - ACL drop on egress leg raises event
// - Eight pairs per leg, IPv4 and IPv6
// - Pair counts only events selected by mask
// - Each pair counts bytes or frames
// - Egress only; counter chosen by IP version
`timescale 1ns/1ps
module egress_router_leg_stats (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Frame descriptors from the routing analyser
  input wire logic frame_valid,
  input wire egress_stats_pkg::frame_desc_t frame_desc,
  // Event outputs, one cycle after the descriptor
  output logic event_valid,
  output logic [egress_stats_pkg::LEG_W-1:0] event_leg,
  output logic [egress_stats_pkg::EVENTS-1:0] event_vec,
  // Avalon-MM slave
  input wire logic [egress_stats_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int NCNT = egress_stats_pkg::LEGS * egress_stats_pkg::PAIRS * 2;

  egress_stats_pkg::pair_cfg_t pair_cfg_reg [egress_stats_pkg::PAIRS];
  logic [7:0] v4_ttl_reg;
  logic [7:0] v6_ttl_reg;
  logic [egress_stats_pkg::SEL_V6_BIT:0] cnt_sel_reg;
  logic [egress_stats_pkg::CNT_W-1:0] cnt_reg [NCNT];
  logic ev_valid_reg;
  logic [egress_stats_pkg::LEG_W-1:0] ev_leg_reg;
  logic [egress_stats_pkg::EVENTS-1:0] ev_vec_reg;
  logic ev_v6_reg;
  logic [egress_stats_pkg::LEN_W-1:0] ev_len_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic wait_reg;
  logic [egress_stats_pkg::EVENTS-1:0] ev_next;
  logic [7:0] ttl_thr;
  logic access;
  logic clear_sel;

  // Counter index from leg, pair and version
  function automatic int cnt_index(input logic [egress_stats_pkg::LEG_W-1:0] leg,
                                   input logic [egress_stats_pkg::PAIR_W-1:0] pair,
                                   input logic v6);
    cnt_index = ((int'(leg) * egress_stats_pkg::PAIRS) + int'(pair)) * 2 + int'(v6);
  endfunction

  // Index of the counter that software has selected
  function automatic int sel_index(input logic [egress_stats_pkg::SEL_V6_BIT:0] sel);
    sel_index = cnt_index(sel[egress_stats_pkg::SEL_PAIR_LSB-1:0],
                          sel[egress_stats_pkg::SEL_V6_BIT-1:egress_stats_pkg::SEL_PAIR_LSB],
                          sel[egress_stats_pkg::SEL_V6_BIT]);
  endfunction

  // Byte address of one pair config word
  function automatic logic [egress_stats_pkg::ADDR_W-1:0] cfg_addr(input int p);
    cfg_addr = egress_stats_pkg::ADDR_W'(p * 4);
  endfunction

  // Readback word of one pair config
  function automatic logic [31:0] cfg_word(input egress_stats_pkg::pair_cfg_t cfg);
    cfg_word = '0;
    cfg_word[egress_stats_pkg::EVENTS-1:0] = cfg.mask;
    cfg_word[egress_stats_pkg::BYTE_MODE_BIT] = cfg.byte_mode;
  endfunction

  // Event generation
  always_comb begin
    ttl_thr = frame_desc.is_v6 ? v6_ttl_reg : v4_ttl_reg;
    ev_next = '0;
    if (frame_desc.acl_dropped) begin
      ev_next[egress_stats_pkg::EV_ACL_DROP] = 1'b1;
    end else if (!frame_desc.is_multicast) begin
      ev_next[egress_stats_pkg::EV_UC_ROUTED] = frame_desc.l3_forwarded;
    end else begin
      // Bridged copies are not subject to the router TTL check
      ev_next[egress_stats_pkg::EV_MC_BRIDGED] = frame_desc.l2_forwarded;
      if (frame_desc.l3_forwarded) begin
        if (frame_desc.ttl < ttl_thr) begin
          ev_next[egress_stats_pkg::EV_MC_TTL_DROP] = 1'b1;
        end else begin
          ev_next[egress_stats_pkg::EV_MC_ROUTED] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_valid_reg <= 1'b0;
      ev_leg_reg <= '0;
      ev_vec_reg <= '0;
      ev_v6_reg <= 1'b0;
      ev_len_reg <= '0;
    end else begin
      ev_valid_reg <= frame_valid;
      ev_leg_reg <= frame_desc.leg;
      ev_vec_reg <= frame_valid ? ev_next : '0;
      ev_v6_reg <= frame_desc.is_v6;
      ev_len_reg <= frame_desc.length;
    end
  end

  assign event_valid = ev_valid_reg;
  assign event_leg = ev_leg_reg;
  assign event_vec = ev_vec_reg;

  // Register bus: request held until the ack cycle drops waitrequest
  assign access = (avs_read || avs_write) && !ack_reg;
  assign clear_sel = ack_reg && avs_write && avs_address == egress_stats_pkg::CNT_VAL_OFF;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
    end
  end

  // Waitrequest from its own flop, low exactly in the answer cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !access;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < egress_stats_pkg::PAIRS; p++) begin
        pair_cfg_reg[p] <= '{mask: egress_stats_pkg::MASK_RESET, byte_mode: 1'b0};
      end
      v4_ttl_reg <= egress_stats_pkg::TTL_RESET;
      v6_ttl_reg <= egress_stats_pkg::TTL_RESET;
      cnt_sel_reg <= '0;
    end else if (ack_reg && avs_write) begin
      for (int p = 0; p < egress_stats_pkg::PAIRS; p++) begin
        if (avs_address == egress_stats_pkg::PAIR_CFG_BASE + cfg_addr(p)) begin
          pair_cfg_reg[p].mask <= avs_writedata[egress_stats_pkg::EVENTS-1:0];
          pair_cfg_reg[p].byte_mode <= avs_writedata[egress_stats_pkg::BYTE_MODE_BIT];
        end
      end
      if (avs_address == egress_stats_pkg::V4_TTL_OFF) begin
        v4_ttl_reg <= avs_writedata[7:0];
      end
      if (avs_address == egress_stats_pkg::V6_TTL_OFF) begin
        v6_ttl_reg <= avs_writedata[7:0];
      end
      if (avs_address == egress_stats_pkg::CNT_SEL_OFF) begin
        cnt_sel_reg <= avs_writedata[egress_stats_pkg::SEL_V6_BIT:0];
      end
    end
  end

  // Counters; a frame update wins over a software clear of the same counter
  // Counters wrap silently, so software must read them before they roll over
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCNT; i++) begin
        cnt_reg[i] <= '0;
      end
    end else begin
      if (clear_sel) begin
        cnt_reg[sel_index(cnt_sel_reg)] <= '0;
      end
      if (ev_valid_reg) begin
        for (int p = 0; p < egress_stats_pkg::PAIRS; p++) begin
          // Any selected event counts the frame once only
          if (|(ev_vec_reg & pair_cfg_reg[p].mask)) begin
            cnt_reg[cnt_index(ev_leg_reg, egress_stats_pkg::PAIR_W'(p), ev_v6_reg)] <=
              cnt_reg[cnt_index(ev_leg_reg, egress_stats_pkg::PAIR_W'(p), ev_v6_reg)] +
              (pair_cfg_reg[p].byte_mode ? egress_stats_pkg::CNT_W'(ev_len_reg) :
               egress_stats_pkg::CNT_W'(1));
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= '0;
      if (access && avs_read) begin
        for (int p = 0; p < egress_stats_pkg::PAIRS; p++) begin
          if (avs_address == egress_stats_pkg::PAIR_CFG_BASE + cfg_addr(p)) begin
            rdata_reg <= cfg_word(pair_cfg_reg[p]);
          end
        end
        unique case (avs_address)
          egress_stats_pkg::CNT_SEL_OFF: rdata_reg <= {26'h0, cnt_sel_reg};
          egress_stats_pkg::CNT_VAL_OFF:
            rdata_reg <= cnt_reg[sel_index(cnt_sel_reg)];
          egress_stats_pkg::V4_TTL_OFF: rdata_reg <= {24'h0, v4_ttl_reg};
          egress_stats_pkg::V6_TTL_OFF: rdata_reg <= {24'h0, v6_ttl_reg};
          default: begin
          end
        endcase
      end
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
endmodule

// File: sim/frame_source.sv
// Routing analyser stand-in: one frame descriptor per bench request.
// Assumes the bench raises send just after a rising clk edge.
`timescale 1ns/1ps
module frame_source (
  // Clock
  input wire logic clk,
  // Bench request
  input wire logic send,
  input wire egress_stats_pkg::frame_desc_t desc_in,
  // Frame port
  output logic frame_valid,
  output egress_stats_pkg::frame_desc_t frame_desc
);
  // Idle descriptor inverted so stale fields never pass for fresh ones
  always_ff @(posedge clk) begin
    frame_valid <= send;
    frame_desc <= send ? desc_in : ~desc_in;
  end
endmodule

// File: sim/egress_router_leg_stats_properties.sv
// Port checker for the egress router leg statistics block.
// Assumes the bind below; sees only the top module's ports.
`timescale 1ns/1ps
module egress_router_leg_stats_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Frame and event ports
  input wire logic frame_valid,
  input wire egress_stats_pkg::frame_desc_t frame_desc,
  input wire logic event_valid,
  input wire logic [egress_stats_pkg::LEG_W-1:0] event_leg,
  input wire logic [egress_stats_pkg::EVENTS-1:0] event_vec,
  // Avalon-MM
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic mc_l3 = frame_valid && frame_desc.is_multicast && frame_desc.l3_forwarded;
  wire logic ok = !frame_desc.acl_dropped;
  sequence s_answer;
    ##1 event_valid ##0 event_leg == $past(frame_desc.leg);
  endsequence
  property p_event; frame_valid |-> s_answer; endproperty
  a_event: assert property (p_event) else $error("event missing or wrong leg");
  property p_idle; !frame_valid |=> !event_valid; endproperty
  a_idle: assert property (p_idle) else $error("event without frame");
  property p_uc;
    frame_valid && !frame_desc.is_multicast && frame_desc.l3_forwarded && ok |=> event_vec == 5'h01;
  endproperty
  a_uc: assert property (p_uc) else $error("unicast routed event wrong");
  property p_mc; mc_l3 && ok && frame_desc.ttl == 8'hff |=> event_vec[1] && !event_vec[3]; endproperty
  a_mc: assert property (p_mc) else $error("multicast routed event wrong");
  property p_br; frame_valid && frame_desc.l2_forwarded && frame_desc.is_multicast && ok |=> event_vec[2];
  endproperty
  a_br: assert property (p_br) else $error("bridged event missing");
  property p_ttl; event_vec[3] |-> $past(mc_l3) && !event_vec[1]; endproperty
  a_ttl: assert property (p_ttl) else $error("ttl drop event wrong");
  property p_acl; frame_valid && !ok |=> event_vec == 5'h10; endproperty
  a_acl: assert property (p_acl) else $error("acl drop event wrong");
  property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not one cycle"); // One wait cycle
endmodule
bind egress_router_leg_stats egress_router_leg_stats_properties chk_i (.clk(clk), .rst(rst),
  .frame_valid(frame_valid), .frame_desc(frame_desc), .event_valid(event_valid),
  .event_leg(event_leg), .event_vec(event_vec), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest));

// File: sim/egress_router_leg_stats_tb.sv
// Self-checking bench: frames through frame_source, counters over Avalon-MM.
// Assumes the package constants and one wait cycle per bus access.
`timescale 1ns/1ps
module egress_router_leg_stats_tb;
  logic clk, rst, send, frame_valid, avs_read, avs_write, avs_waitrequest, event_valid;
  egress_stats_pkg::frame_desc_t desc_in, frame_desc;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0] event_leg;
  logic [4:0] event_vec;
  int bad_count = 0;
  int checks = 0;
  frame_source src (.clk(clk), .send(send), .desc_in(desc_in), .frame_valid(frame_valid),
    .frame_desc(frame_desc));
  egress_router_leg_stats DUT (.clk(clk), .rst(rst), .frame_valid(frame_valid),
    .frame_desc(frame_desc), .event_valid(event_valid), .event_leg(event_leg),
    .event_vec(event_vec), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cnt(input logic [1:0] l, input logic [2:0] p, input logic v6, input int e);
    bus(1, 8'h20, {26'h0, v6, p, l});
    bus(0, 8'h24, 32'h0);
    chk("counter", e, q);
  endtask
  task automatic fr(input logic [1:0] l, input logic [4:0] f, input logic [7:0] t, input int n,
      input int k);
    desc_in <= {l, f, t, n[13:0]};
    send <= 1'b1;
    repeat (k) @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset;
    bus(0, 8'h0c, 0);
    chk("pair cfg", 0, q);
    bus(0, 8'h2c, 0);
    chk("v6 ttl", 1, q);
    bus(0, 8'h28, 0);
    chk("v4 ttl", 1, q);
    bus(1, 8'h40, 32'hffffffff);
    bus(0, 8'h40, 0);
    chk("unmapped", 0, q);
    $display("test reset done");
  endtask
  task automatic t_frames;
    bus(1, 8'h00, 32'h3);
    fr(1, 5'b00100, 8'h40, 100, 2);
    fr(1, 5'b10100, 8'h40, 100, 1);
    fr(1, 5'b00000, 8'h40, 100, 1);
    cnt(1, 0, 0, 2);
    cnt(1, 0, 1, 1);
    cnt(0, 0, 0, 0);
    $display("test frames done");
  endtask
  task automatic t_bytes;
    bus(1, 8'h04, 32'h107);
    fr(2, 5'b11110, 8'hff, 200, 1);
    fr(2, 5'b11101, 8'hff, 77, 1);
    cnt(2, 1, 1, 200);
    cnt(2, 0, 1, 1);
    bus(1, 8'h20, 32'h0e);
    bus(1, 8'h24, 0);
    bus(0, 8'h24, 0);
    chk("cleared", 0, q);
    $display("test bytes done");
  endtask
  task automatic t_drops;
    bus(1, 8'h2c, 32'h40);
    bus(1, 8'h08, 32'h18);
    fr(0, 5'b11100, 8'h20, 60, 1);
    fr(0, 5'b01100, 8'h20, 60, 1);
    fr(0, 5'b00101, 8'h40, 60, 1);
    cnt(0, 2, 1, 1);
    cnt(0, 2, 0, 1);
    $display("test drops done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    {send, avs_read, avs_write, avs_address, avs_writedata, desc_in} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_frames();
    t_bytes();
    t_drops();
    summarize();
  end
endmodule
